// ---- verilog/aclr_resolver.sv ----
/*
 * access control rule resolver: 16 matching, 16 processing and 16 action
 * entries programmed over apb; resolves one action per parsed packet.
 * assumes the header parser presents all fields with a one-cycle valid
 * on the same clock, and the forwarding logic samples the result pulse.
 */
// The APB interface to the registers and the register addresses are this design's own decisions.
// Overview of operation
// - at most one action applied per packet
// - lowest true action pointer wins
// - entries sharing an action are ORed
// - selected matching entries are ANDed together
// - layer and option select; layer 00 disables
// - layer 01: ethertype, mac, or both
// - layer 01 option 00: counter with action value
// - layer 10: masked ip, both ips, reserved
// - layer 11: protocol, tcp, udp port, sequence
// - sixteen ordered entries, all evaluated each packet
// - processing: 16-bit mask and 4-bit pointer
// - counter takes 11-bit value from action entry
`timescale 1ns/1ps
`default_nettype none
`include "aclr_params.svh"

module aclr_resolver
(
    input  wire logic                      clk,           // 50 MHz switch clock
    input  wire logic                      sys_rst,       // async, active high
    input  wire logic                      ce,            // freezes all state when low
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`ACLR_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // parsed header from the ingress parser
    input  wire logic                      pktValid,      // one cycle per packet
    input  wire logic [47:0]               pktDstMac,
    input  wire logic [47:0]               pktSrcMac,
    input  wire logic [15:0]               pktEtherType,
    input  wire logic                      pktIsIpv4,
    input  wire logic [31:0]               pktSrcIp,
    input  wire logic [31:0]               pktDstIp,
    input  wire logic [7:0]                pktProtocol,
    input  wire logic                      pktIsTcp,
    input  wire logic                      pktIsUdp,
    input  wire logic [15:0]               pktSrcPort,
    input  wire logic [15:0]               pktDstPort,
    input  wire logic [31:0]               pktTcpSeq,
    // resolved result towards forwarding
    output logic                           resValid,      // one cycle per packet
    output logic                           resHit,        // an action applies
    output logic [`ACLR_IDX_W-1:0]         resAction,     // chosen action entry
    output logic [31:0]                    resActionData, // its programmed word
    output logic                           resCountHit,   // counter entry matched
    output logic                           irq            // level interrupt
);

    localparam int N = `ACLR_ENTRIES;

    // configuration storage
    logic [`ACLR_CTRL_W-1:0]  matchCtrl [N];   // layer, option, src/dst, equal
    logic [31:0]              matchValA [N];   // mac low, ip, port, proto, seq
    logic [31:0]              matchValB [N];   // mac high, mask or dest ip
    logic [15:0]              matchValC [N];   // ethertype
    logic [15:0]              procMask  [N];   // match_select_mask
    logic [`ACLR_IDX_W-1:0]   procPtr   [N];   // action_pointer
    logic [31:0]              actData   [N];   // action word or count value
    logic [`ACLR_CNT_W-1:0]   cntNow    [N];   // per entry packet counter

    // control and status
    logic [`ACLR_IRQ_W-1:0]   irqStatus;       // sticky events
    logic [`ACLR_IRQ_W-1:0]   irqMask;         // 1 = enabled
    logic                     aclEnable;       // global resolve enable

    // evaluate one matching entry against the packet; counter mode and
    // reserved options give false so they never steer forwarding
    function automatic logic match_eval(input logic [`ACLR_CTRL_W-1:0] ctrl,
                                        input logic [31:0] a,
                                        input logic [31:0] b,
                                        input logic [15:0] c,
                                        input logic        cntMode);
        logic [47:0] mac;
        logic [31:0] ip;
        logic [15:0] port;
        logic        cmp;
        logic        valid;
        mac   = ctrl[`ACLR_F_SRCDST] ? pktSrcMac  : pktDstMac;
        ip    = ctrl[`ACLR_F_SRCDST] ? pktSrcIp   : pktDstIp;
        port  = ctrl[`ACLR_F_SRCDST] ? pktSrcPort : pktDstPort;
        cmp   = 1'b0;
        valid = 1'b0;
        case (aclr_pkg::aclr_layer_t'(ctrl[`ACLR_F_LAYER]))
            aclr_pkg::ACLR_LAYER_L2:
            begin
                valid = 1'b1;
                case (aclr_pkg::aclr_option_t'(ctrl[`ACLR_F_OPTION]))
                    aclr_pkg::ACLR_OPT_1: cmp = (pktEtherType == c);
                    aclr_pkg::ACLR_OPT_2: cmp = (mac == {b[15:0], a});
                    // option 0 is the counter test: mac and type together
                    default:   cmp = (mac == {b[15:0], a}) && (pktEtherType == c);
                endcase
                // counter entries only count, here or in the counter path
                valid = (ctrl[`ACLR_F_OPTION] == 2'h0) ? cntMode : ~cntMode;
            end
            aclr_pkg::ACLR_LAYER_L3:
            begin
                case (aclr_pkg::aclr_option_t'(ctrl[`ACLR_F_OPTION]))
                    aclr_pkg::ACLR_OPT_1:
                    begin
                        valid = pktIsIpv4 & ~cntMode;
                        cmp   = (((ip ^ a) & ~b) == 32'h0000_0000);   // 1 = bit ignored
                    end
                    aclr_pkg::ACLR_OPT_2:
                    begin
                        valid = pktIsIpv4 & ~cntMode;
                        cmp   = (pktSrcIp == a) && (pktDstIp == b);
                    end
                    default: valid = 1'b0;                             // reserved
                endcase
            end
            aclr_pkg::ACLR_LAYER_L4:
            begin
                case (aclr_pkg::aclr_option_t'(ctrl[`ACLR_F_OPTION]))
                    aclr_pkg::ACLR_OPT_0:
                    begin
                        valid = pktIsIpv4 & ~cntMode;
                        cmp   = (pktProtocol == a[7:0]);
                    end
                    aclr_pkg::ACLR_OPT_1:
                    begin
                        valid = pktIsTcp & ~cntMode;
                        cmp   = (port == a[15:0]);
                    end
                    aclr_pkg::ACLR_OPT_2:
                    begin
                        valid = pktIsUdp & ~cntMode;
                        cmp   = (port == a[15:0]);
                    end
                    default:
                    begin
                        valid = pktIsTcp & ~cntMode;
                        cmp   = (pktTcpSeq == a);
                    end
                endcase
            end
            default: valid = 1'b0;
        endcase
        // equal bit picks equal or not-equal as the true result
        return valid & (ctrl[`ACLR_F_EQUAL] ? cmp : ~cmp);
    endfunction : match_eval

    // index of the lowest set bit; lowest number is highest priority
    function automatic logic [`ACLR_IDX_W-1:0] lowest_set(input logic [N-1:0] vec);
        logic [`ACLR_IDX_W-1:0] idx;
        idx = '0;
        for (int k = N - 1; k >= 0; k--)
        begin
            if (vec[k])
            begin
                idx = k[`ACLR_IDX_W-1:0];
            end
        end
        return idx;
    endfunction : lowest_set

    // apb decode
    wire              apbSetup  = psel & ~penable;
    wire              apbAccess = psel & penable;
    wire [3:0]        pageSel   = paddr[11:8];
    wire [1:0]        subSel    = paddr[7:6];
    wire [3:0]        entryM    = paddr[7:4];     // matching entry index
    wire [1:0]        wordM     = paddr[3:2];
    wire [3:0]        entryP    = paddr[5:2];     // proc / action / ctrl index
    wire              hitMatch  = (pageSel == `ACLR_REG_MATCH);
    wire              hitProc   = (pageSel == `ACLR_REG_OTHER) && (subSel == `ACLR_SUB_PROC);
    wire              hitAct    = (pageSel == `ACLR_REG_OTHER) && (subSel == `ACLR_SUB_ACTION);
    wire              hitCtrl   = (pageSel == `ACLR_REG_OTHER) && (subSel == `ACLR_SUB_CTRL)
                                  && (entryP <= `ACLR_CW_ENABLE);
    wire              mapped    = hitMatch | hitProc | hitAct | hitCtrl;
    wire              aligned   = (paddr[1:0] == 2'h0);
    wire              wrEn      = apbAccess & pwrite & mapped & aligned & ce;

    // zero wait state; unmapped or unaligned addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = apbAccess & ~(mapped & aligned);

    // per-entry evaluation, all sixteen for every packet
    logic [N-1:0] matchTrue;    // forwarding matches
    logic [N-1:0] cntTrue;      // counter-mode matches
    logic [N-1:0] cntEntry;     // entry is in counter mode
    logic [N-1:0] procTrue;     // processing entry true
    logic [N-1:0] actVec;       // action entries requested

    // always_comb, not assign: the function reads packet fields directly,
    // and a continuous assignment would not wake when only those change
    always_comb
    begin
        for (int k = 0; k < N; k++)
        begin
            matchTrue[k] = match_eval(matchCtrl[k], matchValA[k], matchValB[k],
                                      matchValC[k], 1'b0);
            cntTrue[k]   = match_eval(matchCtrl[k], matchValA[k], matchValB[k],
                                      matchValC[k], 1'b1);
        end
    end

    for (genvar g = 0; g < N; g++)
    begin : g_eval
        assign cntEntry[g]  = (matchCtrl[g][`ACLR_F_LAYER] == 2'h1)
                              && (matchCtrl[g][`ACLR_F_OPTION] == 2'h0);
        // empty mask selects nothing and never fires
        assign procTrue[g]  = (procMask[g] != 16'h0000)
                              && (&(matchTrue | ~procMask[g]));
    end

    // OR every true processing entry onto its action entry
    always_comb
    begin
        actVec = '0;
        for (int k = 0; k < N; k++)
        begin
            if (procTrue[k])
            begin
                actVec[procPtr[k]] = 1'b1;
            end
        end
        // an action entry lent to a counter holds a count, not an action
        actVec = actVec & ~cntEntry;
    end

    wire                    anyHit   = (actVec != '0) & aclEnable;
    wire [`ACLR_IDX_W-1:0]  winner   = lowest_set(actVec);
    wire                    pktGo    = pktValid & ce;
    wire                    anyCount = (cntTrue != '0) & aclEnable;

    // result register: one action index per packet
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            resValid      <= 1'b0;
            resHit        <= 1'b0;
            resAction     <= '0;
            resActionData <= `ACLR_RST_WORD;
            resCountHit   <= 1'b0;
        end
        else if (ce)
        begin
            resValid    <= pktValid;
            resCountHit <= pktValid & anyCount;
            if (pktValid)
            begin
                resHit        <= anyHit;
                resAction     <= anyHit ? winner : '0;
                resActionData <= anyHit ? actData[winner] : `ACLR_RST_WORD;
            end
        end
    end

    // counter mode: count matched packets up to the action's count value;
    // only the packet-count flavour is kept, timing units are not modelled
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < N; k++)
            begin
                cntNow[k] <= '0;
            end
        end
        else if (pktGo && aclEnable)
        begin
            for (int k = 0; k < N; k++)
            begin
                if (cntTrue[k])
                begin
                    // terminal count restarts the counter
                    cntNow[k] <= (cntNow[k] + 11'h001 >= actData[k][`ACLR_F_COUNT])
                                 ? '0 : cntNow[k] + 11'h001;
                end
            end
        end
    end

    // terminal count across all counter entries
    logic termHit;
    always_comb
    begin
        termHit = 1'b0;
        for (int k = 0; k < N; k++)
        begin
            if (cntTrue[k] && (cntNow[k] + 11'h001 >= actData[k][`ACLR_F_COUNT]))
            begin
                termHit = 1'b1;
            end
        end
    end

    // sticky status: a new event wins over a write-one-to-clear
    wire [`ACLR_IRQ_W-1:0] irqSet = {pktGo & aclEnable & termHit, pktGo & anyHit};
    wire                   clrSel = wrEn & hitCtrl & (entryP == `ACLR_CW_STATUS);
    wire [`ACLR_IRQ_W-1:0] irqClr = clrSel ? pwdata[`ACLR_IRQ_W-1:0] : '0;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqStatus <= '0;
        end
        else if (ce)
        begin
            irqStatus <= (irqStatus & ~irqClr) | irqSet;
        end
    end

    assign irq = |(irqStatus & irqMask);

    // control registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqMask   <= '0;
            aclEnable <= `ACLR_RST_ENABLE;
        end
        else if (wrEn && hitCtrl)
        begin
            if (entryP == `ACLR_CW_MASK)
            begin
                irqMask <= pwdata[`ACLR_IRQ_W-1:0];
            end
            if (entryP == `ACLR_CW_ENABLE)
            begin
                aclEnable <= pwdata[0];
            end
        end
    end

    // table writes; the table is cleared by reset so every entry starts off
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < N; k++)
            begin
                matchCtrl[k] <= `ACLR_RST_CTRL;
                matchValA[k] <= `ACLR_RST_WORD;
                matchValB[k] <= `ACLR_RST_WORD;
                matchValC[k] <= '0;
                procMask[k]  <= '0;
                procPtr[k]   <= '0;
                actData[k]   <= `ACLR_RST_WORD;
            end
        end
        else if (wrEn)
        begin
            if (hitMatch)
            begin
                case (wordM)
                    `ACLR_MW_CTRL: matchCtrl[entryM] <= pwdata[`ACLR_CTRL_W-1:0];
                    `ACLR_MW_VALA: matchValA[entryM] <= pwdata;
                    `ACLR_MW_VALB: matchValB[entryM] <= pwdata;
                    default:       matchValC[entryM] <= pwdata[15:0];
                endcase
            end
            if (hitProc)
            begin
                procMask[entryP] <= pwdata[`ACLR_F_SELMASK];
                procPtr[entryP]  <= pwdata[`ACLR_F_POINTER];
            end
            if (hitAct)
            begin
                actData[entryP] <= pwdata;
            end
        end
    end

    // read mux; unused bits read as zero
    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = '0;
        if (hitMatch)
        begin
            case (wordM)
                `ACLR_MW_CTRL: rdMux = {26'h0, matchCtrl[entryM]};
                `ACLR_MW_VALA: rdMux = matchValA[entryM];
                `ACLR_MW_VALB: rdMux = matchValB[entryM];
                default:       rdMux = {16'h0, matchValC[entryM]};
            endcase
        end
        else if (hitProc)
        begin
            rdMux = {12'h0, procPtr[entryP], procMask[entryP]};
        end
        else if (hitAct)
        begin
            rdMux = actData[entryP];
        end
        else if (hitCtrl)
        begin
            case (entryP)
                `ACLR_CW_STATUS: rdMux = {30'h0, irqStatus};
                `ACLR_CW_MASK:   rdMux = {30'h0, irqMask};
                `ACLR_CW_RESULT: rdMux = {26'h0, resCountHit, resHit, resAction};
                default:         rdMux = {31'h0, aclEnable};
            endcase
        end
    end

    // read data captured in the setup cycle, stable through the access cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata <= `ACLR_RST_WORD;
        end
        else if (ce && apbSetup)
        begin
            prdata <= (mapped && aligned && !pwrite) ? rdMux : `ACLR_RST_WORD;
        end
    end

endmodule : aclr_resolver

`default_nettype wire

// ---- verilog/aclr_params.svh ----
/*
 * constants for the access control rule resolver: register map, field
 * positions, reset values and interrupt bits.
 * assumes it is included by bare name from the package and the design.
 */
`ifndef ACLR_PARAMS_SVH
`define ACLR_PARAMS_SVH

// table size and widths
`define ACLR_ENTRIES        16
`define ACLR_IDX_W          4
`define ACLR_CNT_W          11
`define ACLR_ADDR_W         12

// apb regions, selected by paddr[11:8]
`define ACLR_REG_MATCH      4'h0
`define ACLR_REG_OTHER      4'h1
// sub-regions of the second page, selected by paddr[7:6]
`define ACLR_SUB_PROC       2'h0
`define ACLR_SUB_ACTION     2'h1
`define ACLR_SUB_CTRL       2'h2
// matching entry words, selected by paddr[3:2]
`define ACLR_MW_CTRL        2'h0
`define ACLR_MW_VALA        2'h1
`define ACLR_MW_VALB        2'h2
`define ACLR_MW_VALC        2'h3
// control words, selected by paddr[5:2]
`define ACLR_CW_STATUS      4'h0
`define ACLR_CW_MASK        4'h1
`define ACLR_CW_RESULT      4'h2
`define ACLR_CW_ENABLE      4'h3

// matching entry control word fields
`define ACLR_F_LAYER        1:0
`define ACLR_F_OPTION       3:2
`define ACLR_F_SRCDST       4
`define ACLR_F_EQUAL        5
`define ACLR_CTRL_W         6
// processing entry word fields
`define ACLR_F_SELMASK      15:0
`define ACLR_F_POINTER      19:16
// action word count field
`define ACLR_F_COUNT        10:0

// interrupt status bits
`define ACLR_IRQ_W          2
`define ACLR_IRQ_HIT        0
`define ACLR_IRQ_COUNT      1

// reset values
`define ACLR_RST_WORD       32'h0000_0000
`define ACLR_RST_CTRL       6'h00
`define ACLR_RST_ENABLE     1'b1

`endif

// ---- verilog/aclr_pkg.sv ----
/*
 * types for the access control rule resolver.
 * assumes aclr_params.svh is on the include path.
 */
`default_nettype none
`include "aclr_params.svh"

package aclr_pkg;

    // layer select encoding of a matching entry
    typedef enum logic [1:0]
    {
        ACLR_LAYER_OFF = 2'h0,   // entry disabled
        ACLR_LAYER_L2  = 2'h1,   // mac / ethertype or counter
        ACLR_LAYER_L3  = 2'h2,   // ipv4 address
        ACLR_LAYER_L4  = 2'h3    // protocol, ports, sequence
    } aclr_layer_t;

    // option select encoding, meaning depends on layer
    typedef enum logic [1:0]
    {
        ACLR_OPT_0 = 2'h0,
        ACLR_OPT_1 = 2'h1,
        ACLR_OPT_2 = 2'h2,
        ACLR_OPT_3 = 2'h3
    } aclr_option_t;

endpackage : aclr_pkg

`default_nettype wire

// ---- verification/aclr_resolver_monitor.sv ----
/* concurrent checks on the resolver result timing and apb errors.
   assumes it is bound into aclr_resolver and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module aclr_resolver_monitor
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pktValid,
    input wire logic        resValid,
    input wire logic        resHit,
    input wire logic [3:0]  resAction,
    input wire logic [31:0] resActionData,
    input wire logic        resCountHit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // packet taken by the resolver, and its single answer
    sequence s_take;
        pktValid && ce;
    endsequence
    sequence s_answer;
        resValid;
    endsequence
    a_one_answer: assert property (s_take |=> s_answer)
        else $error("packet got no result");
    a_no_extra: assert property (!(pktValid && ce) |=> !resValid)
        else $error("result without packet");
    a_miss_zero: assert property (resValid && !resHit |-> resAction == 4'h0 &&
        resActionData == 32'h0) else $error("miss carries an action");
    // result must not drift between packets
    a_result_hold: assert property (!(pktValid && ce) |=> $stable(resHit) &&
        $stable(resAction)) else $error("result changed between packets");
    a_count_pulse: assert property (resCountHit |-> resValid)
        else $error("count hit outside result cycle");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("apb access stalled");
    a_err_unmapped: assert property (psel && penable && paddr[11:9] != 3'h0 |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_clean: assert property (psel && penable && paddr[11:8] == 4'h0 &&
        paddr[1:0] == 2'h0 |-> !pslverr) else $error("matching entry access flagged");
endmodule : aclr_resolver_monitor
bind aclr_resolver aclr_resolver_monitor i_mon (.clk, .sys_rst, .ce, .psel, .penable, .paddr,
    .pready, .pslverr, .pktValid, .resValid, .resHit, .resAction, .resActionData, .resCountHit);
`default_nettype wire

// ---- verification/aclr_hdr_src.sv ----
/* header parser stand-in: presents one parsed packet per send call.
   assumes the resolver samples fields only while pktValid is high. */
`timescale 1ns/1ps
`default_nettype none
module aclr_hdr_src
(
    input  wire logic clk,
    output logic        pktValid,
    output logic [47:0] pktDstMac,
    output logic [47:0] pktSrcMac,
    output logic [15:0] pktEtherType,
    output logic        pktIsIpv4,
    output logic [31:0] pktSrcIp,
    output logic [31:0] pktDstIp,
    output logic [7:0]  pktProtocol,
    output logic        pktIsTcp,
    output logic        pktIsUdp,
    output logic [15:0] pktSrcPort,
    output logic [15:0] pktDstPort,
    output logic [31:0] pktTcpSeq
);
    // everything idle at time zero
    initial
    begin
        {pktValid, pktDstMac, pktSrcMac, pktEtherType, pktIsIpv4, pktSrcIp, pktDstIp,
         pktProtocol, pktIsTcp, pktIsUdp, pktSrcPort, pktDstPort, pktTcpSeq} = '0;
    end
    // one tcp over ipv4 packet; fields flip afterwards so stale values never match
    task send(input logic [15:0] et, input logic [31:0] dip, input logic [15:0] dp);
        @(posedge clk);
        pktValid     <= 1'b1;
        pktDstMac    <= 48'h0200_0000_0001;
        pktSrcMac    <= 48'h0200_0000_0002;
        pktEtherType <= et;
        pktIsIpv4    <= 1'b1;
        pktSrcIp     <= 32'h0a00_0001;
        pktDstIp     <= dip;
        pktProtocol  <= 8'h06;
        pktIsTcp     <= 1'b1;
        pktIsUdp     <= 1'b0;
        pktSrcPort   <= 16'h04d2;
        pktDstPort   <= dp;
        pktTcpSeq    <= 32'h0000_0000;
        @(posedge clk);
        pktValid <= 1'b0;
        {pktDstMac, pktSrcMac, pktEtherType, pktSrcIp, pktDstIp, pktProtocol, pktSrcPort,
         pktDstPort, pktTcpSeq} <= ~{pktDstMac, pktSrcMac, pktEtherType, pktSrcIp, pktDstIp,
         pktProtocol, pktSrcPort, pktDstPort, pktTcpSeq};
    endtask : send
endmodule : aclr_hdr_src
`default_nettype wire

// ---- verification/aclr_resolver_tb.sv ----
/* self-checking bench: programs the tables over apb, sends packets.
   assumes aclr_hdr_src as parser and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module aclr_resolver_tb;
    logic clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr, err, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, resActionData;
    logic pktValid, pktIsIpv4, pktIsTcp, pktIsUdp, resValid, resHit, resCountHit;
    logic [47:0] pktDstMac, pktSrcMac;
    logic [31:0] pktSrcIp, pktDstIp, pktTcpSeq;
    logic [15:0] pktEtherType, pktSrcPort, pktDstPort;
    logic [7:0]  pktProtocol;
    logic [3:0]  resAction;
    int numErrors, comparisons, cycles;
    // {address, word}: ethertype, both ips, tcp dst port; three processing entries
    localparam logic [43:0] PROG [12] = '{44'h000_0000_0025, 44'h00c_0000_0800,
        44'h010_0000_002a, 44'h014_0a00_0001, 44'h018_0a00_0002, 44'h020_0000_0027,
        44'h024_0000_0050, 44'h100_0003_0006, 44'h104_0005_0001, 44'h108_0003_0004,
        44'h14c_0000_0033, 44'h154_0000_0055};
    // packet counter on entry 4, terminal at 2, irq on terminal only
    localparam logic [43:0] CNT [6] = '{44'h040_0000_0021, 44'h044_0000_0001,
        44'h048_0000_0200, 44'h04c_0000_0800, 44'h150_0000_0002, 44'h184_0000_0002};
    aclr_resolver i_dut (.clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pktValid, .pktDstMac, .pktSrcMac, .pktEtherType,
        .pktIsIpv4, .pktSrcIp, .pktDstIp, .pktProtocol, .pktIsTcp, .pktIsUdp, .pktSrcPort,
        .pktDstPort, .pktTcpSeq, .resValid, .resHit, .resAction, .resActionData,
        .resCountHit, .irq);
    aclr_hdr_src i_src (.clk, .pktValid, .pktDstMac, .pktSrcMac, .pktEtherType, .pktIsIpv4,
        .pktSrcIp, .pktDstIp, .pktProtocol, .pktIsTcp, .pktIsUdp, .pktSrcPort, .pktDstPort,
        .pktTcpSeq);
    // 50 MHz clock
    always #10 clk = ~clk;
    task conclude;
        $display("errors %0d comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            numErrors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; waits for pready, never assumes a latency
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    // send a packet and check the result one cycle later
    task pkt(input logic [15:0] et, input logic [31:0] dip, input logic [15:0] dp,
             input logic h, input logic [3:0] act, input logic [31:0] dat, input logic c);
        i_src.send(et, dip, dp);
        #1;
        chk(resValid, 1);
        chk(resHit, h);
        chk(resAction, act);
        chk(resActionData, dat);
        chk(resCountHit, c);
    endtask : pkt
    // hang guard: far above the hundred or so cycles needed
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            numErrors++;
            conclude();
        end
    end
    initial
    begin
        {clk, psel, penable, pwrite, paddr, pwdata, cycles} = '0;
        sys_rst = 1'b1;
        ce = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        apb(0, 12'h18c, 0);
        chk(rdv, 32'h1);
        apb(0, 12'h200, 0);
        chk({rdv[30:0], err}, 32'h1);
        foreach (PROG[i]) apb(1, PROG[i][43:32], PROG[i][31:0]);
        apb(0, 12'h100, 0);
        chk(rdv, 32'h0003_0006);
        pkt(16'h0800, 32'h0a00_0002, 16'd80, 1, 4'h3, 32'h33, 0);
        pkt(16'h0800, 32'h0a00_0009, 16'd80, 1, 4'h3, 32'h33, 0);
        pkt(16'h0800, 32'h0a00_0002, 16'd81, 1, 4'h5, 32'h55, 0);
        apb(0, 12'h188, 0);
        chk(rdv, 32'h15);
        pkt(16'h86dd, 32'h0a00_0002, 16'd81, 0, 4'h0, 32'h0, 0);
        apb(1, 12'h000, 32'h24);
        pkt(16'h0800, 32'h0a00_0002, 16'd81, 0, 4'h0, 32'h0, 0);
        // entry 0 as masked ip: only the top byte of the destination counts
        apb(1, 12'h000, 32'h26);
        apb(1, 12'h008, 32'h00ff_ffff);
        pkt(16'h0800, 32'h0000_0002, 16'd81, 1, 4'h5, 32'h55, 0);
        foreach (CNT[i]) apb(1, CNT[i][43:32], CNT[i][31:0]);
        // a packet offered with ce low must neither answer nor count
        @(posedge clk) ce <= 1'b0;
        i_src.send(16'h0800, 32'h0a00_0002, 16'd81);
        #1;
        chk(resValid, 0);
        @(posedge clk) ce <= 1'b1;
        pkt(16'h0800, 32'h0a00_0002, 16'd81, 0, 4'h0, 32'h0, 1);
        chk(irq, 0);
        pkt(16'h0800, 32'h0a00_0002, 16'd81, 0, 4'h0, 32'h0, 1);
        chk(irq, 1);
        apb(1, 12'h180, 32'h2);
        chk(irq, 0);
        apb(0, 12'h180, 0);
        chk(rdv, 32'h1);
        conclude();
    end
endmodule : aclr_resolver_tb
`default_nettype wire
